// [pkg/cbo_cfg.svh]
// Offsets, field positions, reset values and constants of the enable register bank
`ifndef CBO_CFG_SVH
`define CBO_CFG_SVH

`define CBO_SLAVE_ADDR    7'h6C
`define CBO_CMD_BLOCK_BIT 7

`define CBO_OFS_RCA  7'h00
`define CBO_OFS_OEL  7'h01
`define CBO_OFS_OEH  7'h02
`define CBO_OFS_RDBK 7'h03
`define CBO_OFS_RCB  7'h04
`define CBO_OFS_MREV 7'h05
`define CBO_OFS_PART 7'h06
`define CBO_OFS_BLEN 7'h07
`define CBO_OFS_OSET 7'h08
`define CBO_OFS_TRIM 7'h4C

`define CBO_RST_RCA  8'h47
`define CBO_RST_OEL  8'hFF
`define CBO_RST_OEH  8'h0F
`define CBO_RST_RDBK 8'h00
`define CBO_RST_RCB  8'h00
`define CBO_RST_BLEN 8'h08
`define CBO_RST_OSET 8'h00
`define CBO_RST_TRIM 8'h66
// Identity values are arbitrary
`define CBO_IDENT_MREV 8'h5A
`define CBO_IDENT_PART 8'h3C

`define CBO_RCA_RO_HI  4'h4
`define CBO_BIT_EN_CH0 2
`define CBO_BIT_EN_CH1 5
`define CBO_BIT_EN_CH2 0
`define CBO_BIT_EN_CH3 2
`define CBO_BIT_PIN_CH0 1
`define CBO_BIT_PIN_CH1 3
`define CBO_BIT_PIN_CH2 6
`define CBO_BIT_PIN_CH3 7
`define CBO_BLEN_BITS  5

`endif

// [pkg/cbo_pkg.sv]
// Types shared by the enable register bank
package cbo_pkg;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ACK_ADDR  = 4'h2,
        ST_CMD       = 4'h3,
        ST_ACK_CMD   = 4'h4,
        ST_WDATA     = 4'h5,
        ST_ACK_WDATA = 4'h6,
        ST_RDATA     = 4'h7,
        ST_RACK      = 4'h8
    } cbo_state_t;

    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } cbo_wr_t;

endpackage

// [rtl/cbo_enable_regs.sv]
// SMBus slave, output enable gating and register bank of the four-channel buffer
`timescale 1ns/1ps
`include "cbo_cfg.svh"

module cbo_enable_regs (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_scl,
    input  wire logic i_sda,
    input  wire logic i_pwrgood_pdown_n,
    input  wire logic i_hw_enable_n_ch0,
    input  wire logic i_hw_enable_n_ch1,
    input  wire logic i_hw_enable_n_ch2,
    input  wire logic i_hw_enable_n_ch3,
    output logic      o_sda,
    output logic      o_sda_oe,
    output logic      o_clk_out_ch0_en,
    output logic      o_clk_out_ch1_en,
    output logic      o_clk_out_ch2_en,
    output logic      o_clk_out_ch3_en
);

    cbo_pkg::cbo_state_t state;
    cbo_pkg::cbo_wr_t    wr;

    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [6:0] ptr;
    logic [7:0] cmd_q;
    logic       blk;
    logic       cnt_phase;
    logic       rd_mode;
    logic       wr_done;
    logic [7:0] remain;
    logic [7:0] rdata;
    logic [3:0] sw_en;
    logic [3:0] hw_n;
    logic [3:0] drive;
    logic [4:0] read_len;
    logic [7:0] tx_byte;
    logic [1:0] live;

    logic pg;
    logic start_c;
    logic stop_c;
    logic rise;
    logic fall;

    ////////////////////////////////////////////////////////////////////////
    // Bus edge detection

    assign pg      = i_pwrgood_pdown_n;
    assign start_c = i_scl & scl_q & sda_q & ~i_sda;
    assign stop_c  = i_scl & scl_q & ~sda_q & i_sda;
    assign rise    = i_scl & ~scl_q;
    assign fall    = ~i_scl & scl_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
        end
    end

    // First byte of a block read is the length
    assign tx_byte = (blk && cnt_phase) ? {3'h0, read_len} : rdata;

    ////////////////////////////////////////////////////////////////////////
    // Transfer engine

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= cbo_pkg::ST_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            ptr       <= 7'h00;
            cmd_q     <= 8'h00;
            blk       <= 1'b0;
            cnt_phase <= 1'b0;
            rd_mode   <= 1'b0;
            wr_done   <= 1'b0;
            remain    <= 8'h00;
            o_sda_oe  <= 1'b0;
            wr        <= '0;
        end else begin
            wr.we <= 1'b0;
            if (!pg) begin
                state    <= cbo_pkg::ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (start_c) begin
                state    <= cbo_pkg::ST_ADDR;
                bit_cnt  <= 4'h0;
                o_sda_oe <= 1'b0;
            end else if (stop_c) begin
                state    <= cbo_pkg::ST_IDLE;
                o_sda_oe <= 1'b0;
            end else begin
                unique case (state)
                    cbo_pkg::ST_IDLE: begin
                        o_sda_oe <= 1'b0;
                    end
                    cbo_pkg::ST_ADDR, cbo_pkg::ST_CMD, cbo_pkg::ST_WDATA: begin
                        if (rise && bit_cnt != 4'h8) begin
                            shift   <= {shift[6:0], i_sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (fall && bit_cnt == 4'h8) begin
                            if (state == cbo_pkg::ST_ADDR) begin
                                if (shift[7:1] == `CBO_SLAVE_ADDR) begin
                                    rd_mode  <= shift[0];
                                    o_sda_oe <= 1'b1;
                                    state    <= cbo_pkg::ST_ACK_ADDR;
                                end else begin
                                    state <= cbo_pkg::ST_IDLE;
                                end
                            end else if (state == cbo_pkg::ST_CMD) begin
                                cmd_q     <= shift;
                                ptr       <= shift[6:0];
                                blk       <= shift[`CBO_CMD_BLOCK_BIT];
                                cnt_phase <= shift[`CBO_CMD_BLOCK_BIT];
                                wr_done   <= 1'b0;
                                o_sda_oe  <= 1'b1;
                                state     <= cbo_pkg::ST_ACK_CMD;
                            end else if (blk && cnt_phase) begin
                                remain    <= shift;
                                cnt_phase <= 1'b0;
                                o_sda_oe  <= 1'b1;
                                state     <= cbo_pkg::ST_ACK_WDATA;
                            end else if (blk ? (remain != 8'h00) : !wr_done) begin
                                wr.we    <= 1'b1;
                                wr.addr  <= ptr;
                                wr.data  <= shift;
                                ptr      <= ptr + 7'h01;
                                remain   <= blk ? remain - 8'h01 : remain;
                                wr_done  <= 1'b1;
                                o_sda_oe <= 1'b1;
                                state    <= cbo_pkg::ST_ACK_WDATA;
                            end else begin
                                // Surplus byte is refused
                                state <= cbo_pkg::ST_IDLE;
                            end
                        end
                    end
                    cbo_pkg::ST_ACK_ADDR: begin
                        if (fall) begin
                            bit_cnt <= 4'h0;
                            if (rd_mode) begin
                                shift    <= tx_byte;
                                o_sda_oe <= ~tx_byte[7];
                                bit_cnt  <= 4'h1;
                                state    <= cbo_pkg::ST_RDATA;
                            end else begin
                                o_sda_oe <= 1'b0;
                                state    <= cbo_pkg::ST_CMD;
                            end
                        end
                    end
                    cbo_pkg::ST_ACK_CMD, cbo_pkg::ST_ACK_WDATA: begin
                        if (fall) begin
                            o_sda_oe <= 1'b0;
                            bit_cnt  <= 4'h0;
                            state    <= cbo_pkg::ST_WDATA;
                        end
                    end
                    cbo_pkg::ST_RDATA: begin
                        if (fall) begin
                            if (bit_cnt != 4'h8) begin
                                o_sda_oe <= ~shift[6];
                                shift    <= {shift[6:0], 1'b0};
                                bit_cnt  <= bit_cnt + 4'h1;
                            end else begin
                                o_sda_oe <= 1'b0;
                                state    <= cbo_pkg::ST_RACK;
                                if (blk && cnt_phase) begin
                                    cnt_phase <= 1'b0;
                                end else begin
                                    ptr <= ptr + 7'h01;
                                end
                            end
                        end
                    end
                    cbo_pkg::ST_RACK: begin
                        if (rise && i_sda) begin
                            state <= cbo_pkg::ST_IDLE;
                        end else if (fall) begin
                            shift    <= tx_byte;
                            o_sda_oe <= ~tx_byte[7];
                            bit_cnt  <= 4'h1;
                            state    <= cbo_pkg::ST_RDATA;
                        end
                    end
                    default: begin
                        state    <= cbo_pkg::ST_IDLE;
                        o_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open drain: only ever pulls low
    assign o_sda = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    assign hw_n = {i_hw_enable_n_ch3, i_hw_enable_n_ch2,
                   i_hw_enable_n_ch1, i_hw_enable_n_ch0};

    cbo_regfile u_regs (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_wr        (wr),
        .i_rd_addr   (ptr),
        .i_pin_level (hw_n),
        .o_rdata     (rdata),
        .o_sw_enable (sw_en),
        .o_read_len  (read_len)
    );

    ////////////////////////////////////////////////////////////////////////
    // Channel gating

    for (genvar g = 0; g < 4; g++) begin : g_chan
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                drive[g] <= 1'b0;
            end else begin
                drive[g] <= sw_en[g] & ~hw_n[g] & pg;
            end
        end

        property p_drive_on;
            @(posedge i_clk) disable iff (!i_rst_n)
            (pg && sw_en[g] && !hw_n[g]) [*2] |-> drive[g];
        endproperty
        a_drive_on: assert property (p_drive_on)
            else $error("enabled channel not driving");

        property p_drive_off;
            @(posedge i_clk) disable iff (!i_rst_n)
            (!sw_en[g] || hw_n[g]) |=> !drive[g];
        endproperty
        a_drive_off: assert property (p_drive_off)
            else $error("disabled channel still driving");
    end

    assign o_clk_out_ch0_en = drive[0];
    assign o_clk_out_ch1_en = drive[1];
    assign o_clk_out_ch2_en = drive[2];
    assign o_clk_out_ch3_en = drive[3];

    ////////////////////////////////////////////////////////////////////////
    // Checks

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            live <= 2'h0;
        end else begin
            live <= {live[0], 1'b1};
        end
    end

    property p_rca_upper;
        @(posedge i_clk) disable iff (!i_rst_n)
        (live[0] && $past(ptr) == `CBO_OFS_RCA) |-> (rdata[7:4] == `CBO_RCA_RO_HI);
    endproperty
    a_rca_upper: assert property (p_rca_upper)
        else $error("reserved_ctrl_a upper nibble wrong");

    property p_en_ch1;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr.we && wr.addr == `CBO_OFS_OEL) |=> (sw_en[1] == $past(wr.data[5]));
    endproperty
    a_en_ch1: assert property (p_en_ch1)
        else $error("channel 1 enable not taken from bit 5");

    property p_en_ch0;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr.we && wr.addr == `CBO_OFS_OEL) |=> (sw_en[0] == $past(wr.data[2]));
    endproperty
    a_en_ch0: assert property (p_en_ch0)
        else $error("channel 0 enable not taken from bit 2");

    property p_en_ch3;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr.we && wr.addr == `CBO_OFS_OEH) |=> (sw_en[3] == $past(wr.data[2]));
    endproperty
    a_en_ch3: assert property (p_en_ch3)
        else $error("channel 3 enable not taken from bit 2");

    property p_en_ch2;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr.we && wr.addr == `CBO_OFS_OEH) |=> (sw_en[2] == $past(wr.data[0]));
    endproperty
    a_en_ch2: assert property (p_en_ch2)
        else $error("channel 2 enable not taken from bit 0");

    property p_rdbk_hi;
        @(posedge i_clk) disable iff (!i_rst_n)
        (live[1] && $past(ptr) == `CBO_OFS_RDBK) |->
            (rdata[7] == $past(hw_n[3], 2) && rdata[6] == $past(hw_n[2], 2));
    endproperty
    a_rdbk_hi: assert property (p_rdbk_hi)
        else $error("readback of channels 3 and 2 wrong");

    property p_rdbk_lo;
        @(posedge i_clk) disable iff (!i_rst_n)
        (live[1] && $past(ptr) == `CBO_OFS_RDBK) |->
            (rdata[3] == $past(hw_n[1], 2) && rdata[1] == $past(hw_n[0], 2)
             && rdata[5:4] == 2'h0 && rdata[2] == 1'b0 && rdata[0] == 1'b0);
    endproperty
    a_rdbk_lo: assert property (p_rdbk_lo)
        else $error("readback of channels 1 and 0 wrong");

    property p_rcb_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        (live[0] && $past(ptr) == `CBO_OFS_RCB) |-> (rdata == 8'h00);
    endproperty
    a_rcb_zero: assert property (p_rcb_zero)
        else $error("reserved_ctrl_b not zero");

    property p_ro_write;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr.we && (wr.addr == `CBO_OFS_RDBK || wr.addr == `CBO_OFS_RCB)) |=>
            $stable({u_regs.rca_lo, u_regs.oel, u_regs.oeh, u_regs.blen});
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write changed a read-only register");

    property p_byte_addr;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr.we && !blk) |-> (wr.addr == cmd_q[6:0] && !cmd_q[7]);
    endproperty
    a_byte_addr: assert property (p_byte_addr)
        else $error("byte write not at command address");

    property p_pdown_quiet;
        @(posedge i_clk) disable iff (!i_rst_n)
        (!pg) [*2] |-> (!o_sda_oe && state == cbo_pkg::ST_IDLE);
    endproperty
    a_pdown_quiet: assert property (p_pdown_quiet)
        else $error("serial port active in power-down");

endmodule // cbo_enable_regs

// [rtl/cbo_regfile.sv]
// Register storage and read mux of the enable register bank
`timescale 1ns/1ps
`include "cbo_cfg.svh"

module cbo_regfile (
    input  wire logic            i_clk,
    input  wire logic            i_rst_n,
    input  wire cbo_pkg::cbo_wr_t i_wr,
    input  wire logic [6:0]      i_rd_addr,
    input  wire logic [3:0]      i_pin_level,
    output logic [7:0]           o_rdata,
    output logic [3:0]           o_sw_enable,
    output logic [4:0]           o_read_len
);

    logic [3:0] rca_lo;
    logic [7:0] oel;
    logic [7:0] oeh;
    logic [7:0] rdbk;
    logic [7:0] blen;
    logic [5:0] oset;
    logic [7:0] trim;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rca_lo <= 4'(`CBO_RST_RCA);
            oel    <= `CBO_RST_OEL;
            oeh    <= `CBO_RST_OEH;
            blen   <= `CBO_RST_BLEN;
            oset   <= 6'h00;
            trim   <= `CBO_RST_TRIM;
        end else if (i_wr.we) begin
            case (i_wr.addr)
                `CBO_OFS_RCA:  rca_lo <= i_wr.data[3:0];
                `CBO_OFS_OEL:  oel    <= i_wr.data;
                `CBO_OFS_OEH:  oeh    <= i_wr.data;
                `CBO_OFS_BLEN: blen   <= i_wr.data;
                `CBO_OFS_OSET: oset   <= i_wr.data[5:0];
                `CBO_OFS_TRIM: trim   <= i_wr.data;
                default: ;
            endcase
        end
    end

    // Live pin levels
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdbk <= `CBO_RST_RDBK;
        end else begin
            rdbk                   <= 8'h00;
            rdbk[`CBO_BIT_PIN_CH0] <= i_pin_level[0];
            rdbk[`CBO_BIT_PIN_CH1] <= i_pin_level[1];
            rdbk[`CBO_BIT_PIN_CH2] <= i_pin_level[2];
            rdbk[`CBO_BIT_PIN_CH3] <= i_pin_level[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            case (i_rd_addr)
                `CBO_OFS_RCA:  o_rdata <= {`CBO_RCA_RO_HI, rca_lo};
                `CBO_OFS_OEL:  o_rdata <= oel;
                `CBO_OFS_OEH:  o_rdata <= oeh;
                `CBO_OFS_RDBK: o_rdata <= rdbk;
                `CBO_OFS_RCB:  o_rdata <= `CBO_RST_RCB;
                `CBO_OFS_MREV: o_rdata <= `CBO_IDENT_MREV;
                `CBO_OFS_PART: o_rdata <= `CBO_IDENT_PART;
                `CBO_OFS_BLEN: o_rdata <= blen;
                `CBO_OFS_OSET: o_rdata <= {2'h0, oset};
                `CBO_OFS_TRIM: o_rdata <= trim;
                default:       o_rdata <= 8'h00;
            endcase
        end
    end

    assign o_sw_enable[0] = oel[`CBO_BIT_EN_CH0];
    assign o_sw_enable[1] = oel[`CBO_BIT_EN_CH1];
    assign o_sw_enable[2] = oeh[`CBO_BIT_EN_CH2];
    assign o_sw_enable[3] = oeh[`CBO_BIT_EN_CH3];
    assign o_read_len     = blen[`CBO_BLEN_BITS-1:0];

endmodule // cbo_regfile

// [test/cbo_host_model.sv]
// SMBus host model driving the clock and data wires of the enable register bank
`timescale 1ns/1ps

module cbo_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_sda_wire,
    output logic            o_scl,
    output logic            o_sda_drv,
    output logic            o_rd_valid,
    output logic [7:0]      o_rd_data
);
    initial begin
        o_scl      = 1'b1;
        o_sda_drv  = 1'b1;
        o_rd_valid = 1'b0;
        o_rd_data  = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One clock period: data moves mid-low, optional change while clock is high
    task automatic frame(input logic a, input logic b);
        o_scl <= 1'b0;
        repeat (2) @(posedge i_clk);
        o_sda_drv <= a;
        repeat (2) @(posedge i_clk);
        o_scl <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_sda_drv <= b;
        repeat (4) @(posedge i_clk);
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ack_drv, output logic [7:0] r,
                         output logic ack);
        for (int i = 7; i >= 0; i--) begin
            frame(d[i], d[i]);
            r[i] = i_sda_wire;
        end
        frame(ack_drv, ack_drv);
        ack = ~i_sda_wire;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Byte write; only mapped offsets are ever addressed
    task automatic write_reg(input logic [6:0] ofs, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        frame(1'b1, 1'b0);
        xbyte(8'hD8, 1'b1, r, a0);
        xbyte({1'b0, ofs}, 1'b1, r, a1);
        xbyte(d, 1'b1, r, a2);
        frame(1'b0, 1'b1);
        ok = a0 & a1 & a2;
    endtask

    // Block write: count of two, two data bytes, then a surplus byte that must be refused
    task automatic write_blk(input logic [6:0] ofs, input logic [7:0] d0, input logic [7:0] d1,
                             output logic ok);
        logic [7:0] r;
        logic [5:0] a;
        frame(1'b1, 1'b0);
        xbyte(8'hD8, 1'b1, r, a[0]);
        xbyte({1'b1, ofs}, 1'b1, r, a[1]);
        xbyte(8'h02, 1'b1, r, a[2]);
        xbyte(d0, 1'b1, r, a[3]);
        xbyte(d1, 1'b1, r, a[4]);
        xbyte(8'hFF, 1'b1, r, a[5]);
        frame(1'b0, 1'b1);
        ok = (&a[4:0]) & ~a[5];
    endtask

    // Byte or block read by command; last byte is refused to end the read
    task automatic read_seq(input logic [7:0] cmd, input int n, output logic ok);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        frame(1'b1, 1'b0);
        xbyte(8'hD8, 1'b1, r, a0);
        xbyte(cmd, 1'b1, r, a1);
        frame(1'b1, 1'b0);
        xbyte(8'hD9, 1'b1, r, a2);
        for (int k = 0; k < n; k++) begin
            xbyte(8'hFF, (k == n - 1), r, a3);
            o_rd_data  <= r;
            o_rd_valid <= 1'b1;
            @(posedge i_clk);
            o_rd_valid <= 1'b0;
        end
        frame(1'b0, 1'b1);
        ok = a0 & a1 & a2;
    endtask
endmodule // cbo_host_model

// [test/tb_cbo_enable_regs.sv]
// Self-checking bench of the enable register bank
`timescale 1ns/1ps

module tb_cbo_enable_regs;
    logic        i_clk;
    logic        i_rst_n;
    logic        scl;
    logic        sda_drv;
    logic        sda_wire;
    logic        pg;
    logic [3:0]  pin_n;
    logic        o_sda;
    logic        o_sda_oe;
    logic [3:0]  en;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic [7:0]  exp_q[$];
    logic [7:0]  r1;
    logic [7:0]  r2;
    logic [31:0] rnd;
    logic        ok;
    integer      seed;
    int          mismatches;
    int          tests_run;

    // Open-drain data wire with pull-up
    assign sda_wire = sda_drv & ~(o_sda_oe & ~o_sda);

    cbo_enable_regs cbo_enable_regs_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_wire),
        .i_pwrgood_pdown_n(pg), .i_hw_enable_n_ch0(pin_n[0]), .i_hw_enable_n_ch1(pin_n[1]),
        .i_hw_enable_n_ch2(pin_n[2]), .i_hw_enable_n_ch3(pin_n[3]), .o_sda(o_sda),
        .o_sda_oe(o_sda_oe), .o_clk_out_ch0_en(en[0]), .o_clk_out_ch1_en(en[1]),
        .o_clk_out_ch2_en(en[2]), .o_clk_out_ch3_en(en[3]));
    cbo_host_model cbo_host_model_i (
        .i_clk(i_clk), .i_sda_wire(sda_wire), .o_scl(scl), .o_sda_drv(sda_drv),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data));

    initial i_clk = 1'b0;
    always #20 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic fail(input string msg);
        mismatches++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
    endtask
    task automatic cmp_ack(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) fail($sformatf("acknowledge %b expected %b", got, exp));
    endtask
    task automatic cmp_en(input logic [3:0] exp);
        repeat (3) @(posedge i_clk);
        tests_run++;
        if (en !== exp) fail($sformatf("enables %b expected %b", en, exp));
    endtask
    function automatic logic [7:0] rdbk(input logic [3:0] p);
        return {p[3], p[2], 2'b00, p[1], 1'b0, p[0], 1'b0};
    endfunction
    task automatic read_map(input logic [7:0] v0, input logic [7:0] v1, input logic [7:0] v2);
        exp_q.push_back(8'h08);
        exp_q.push_back(v0);
        exp_q.push_back(v1);
        exp_q.push_back(v2);
        exp_q.push_back(rdbk(pin_n));
        exp_q.push_back(8'h00);
        cbo_host_model_i.read_seq(8'h80, 6, ok);
        cmp_ack(ok, 1'b1);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Read results are matched against the oldest expectation
    always @(posedge i_clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) fail("read byte with nothing expected");
            else cmp_byte(rd_data, exp_q.pop_front());
        end
    end

    initial begin
        repeat (60000) @(posedge i_clk);
        fail("run did not finish in time");
        results();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h7c8f1b19;
        i_rst_n = 1'b0;
        pg = 1'b1;
        pin_n = 4'h0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rnd = $random(seed);
        pin_n <= rnd[3:0];
        repeat (3) @(posedge i_clk);
        read_map(8'h47, 8'hFF, 8'h0F);
        cmp_en({4'hF} & ~pin_n);
        $display("test reset values done");
        for (int t = 0; t < 4; t++) begin
            rnd = $random(seed);
            r1 = rnd[7:0];
            r2 = rnd[15:8];
            pin_n <= rnd[19:16];
            cbo_host_model_i.write_reg(7'h01, r1, ok);
            cmp_ack(ok, 1'b1);
            cbo_host_model_i.write_reg(7'h02, r2, ok);
            cmp_ack(ok, 1'b1);
            cmp_en({r2[2], r2[0], r1[5], r1[2]} & ~pin_n);
            read_map(8'h47, r1, r2);
        end
        $display("test enables and readback done");
        for (int a = 0; a < 5; a++) begin
            cbo_host_model_i.write_reg(a[6:0], 8'h00, ok);
            if (a != 1 && a != 2) cbo_host_model_i.write_reg(a[6:0], 8'hFF, ok);
        end
        r1 = 8'h00;
        r2 = 8'h00;
        read_map(8'h4F, 8'h00, 8'h00);
        exp_q.push_back(8'h00);
        cbo_host_model_i.read_seq(8'h04, 1, ok);
        $display("test read-only writes done");
        cbo_host_model_i.write_reg(7'h01, 8'hA5, ok);
        pg <= 1'b0;
        pin_n <= 4'h0;
        cmp_en(4'h0);
        cbo_host_model_i.write_reg(7'h01, 8'h00, ok);
        cmp_ack(ok, 1'b0);
        pg <= 1'b1;
        cmp_en(4'h3);
        exp_q.push_back(8'hA5);
        cbo_host_model_i.read_seq(8'h01, 1, ok);
        $display("test power-down done");
        cbo_host_model_i.write_blk(7'h00, 8'hF2, 8'h14, ok);
        cmp_ack(ok, 1'b1);
        cmp_en(4'h1);
        read_map(8'h42, 8'h14, 8'h00);
        $display("test block write done");
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        read_map(8'h47, 8'hFF, 8'h0F);
        $display("test second reset done");
        repeat (4) @(posedge i_clk);
        if (exp_q.size() != 0) fail("expected reads never arrived");
        results();
    end
endmodule // tb_cbo_enable_regs
